// file: hw/serial_port_status_flags.v
// Contract
// - Eight activity bits, one per remote unit 0 to 7.
// - Activity bit of the unit exchanging data is set in either mode.
// - Restart request reinitialises port, then self-clears when done.
// - Error field: parity bit 2, framing 3, overrun 4, timeout 5.
// - Error bits 0, 1, 6, 7 always read zero.
// - Receive or link errors are recorded in the error field; parity errors are never recorded, in any mode.
// - Terminal link mode records only timeout errors.
// - Peer polling unit: timeout only; polled unit: timeout, overrun, framing.
// - Polling unit keeps retrying after peer link error without restart.
// - Communication resumes automatically once error cause is gone.
// - Error flags stay set until a port restart, or a write of 0 to the bit, clears them.
// - Settings-change flag set on update, held while applying, then cleared.
// - Reset clears activity, restart, error and settings-change flags.
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "serial_flags_defs.vh"
module serial_port_status_flags #(
    parameter LINK_TIMEOUT_CYC = `LINK_TIMEOUT_CYC
) (
    input wire core_clk,
    input wire rst_n,
    input wire clk_en,
    // AHB-Lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Link engine events, same clock, one-cycle pulses
    input wire [2:0] rx_unit,
    input wire rx_unit_valid,
    input wire parity_err,
    input wire framing_err,
    input wire overrun_err,
    input wire timeout_err,
    input wire settings_update,
    // Port control toward the link engine
    output reg port_reinit,
    output reg retry_poll,
    output reg link_enable,
    output reg settings_busy,
    output reg irq
);
    ////////////////////////////////////////////////////////////////////
    // Bus front end
    reg wr_pend_reg;
    reg rd_pend_reg;
    reg [11:0] addr_reg;
    wire take = hsel && hready && htrans[1];
    always @(posedge core_clk) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 12'h000;
        end else if (clk_en) begin
            wr_pend_reg <= take && hwrite;
            rd_pend_reg <= take && !hwrite;
            if (take) begin
                addr_reg <= haddr;
            end
        end
    end
    wire wr = clk_en && wr_pend_reg;
    wire rd_take = clk_en && take && !hwrite;
    ////////////////////////////////////////////////////////////////////
    // Control registers
    reg restart_reg;
    reg [1:0] mode_reg;
    reg [7:0] err_reg;
    reg [`IRQ_WIDTH-1:0] irq_stat_reg;
    reg [`IRQ_WIDTH-1:0] irq_mask_reg;
    reg sw_settings_reg;
    wire restart_busy;
    wire restart_done;
    wire cfg_busy;
    wire cfg_done;
    wire [7:0] activity;
    wire peer = mode_reg[`MODE_PEER_BIT];
    wire polled = mode_reg[`MODE_POLLED_BIT];
    wire wr_restart = wr && addr_reg == `OFF_RESTART && hwdata[0];
    // Mode-dependent enabling of error bits
    reg [7:0] err_allow;
    always @* begin
        err_allow = 8'h00;
        err_allow[`ERR_TIMEOUT] = 1'b1;
        if (peer && polled) begin
            err_allow[`ERR_OVERRUN] = 1'b1;
            err_allow[`ERR_FRAMING] = 1'b1;
        end
    end
    reg [7:0] err_evt;
    always @* begin
        err_evt = 8'h00;
        err_evt[`ERR_PARITY] = parity_err;
        err_evt[`ERR_FRAMING] = framing_err;
        err_evt[`ERR_OVERRUN] = overrun_err;
        err_evt[`ERR_TIMEOUT] = timeout_err;
    end
    wire [7:0] err_hit = err_evt & err_allow & `ERR_USED_MASK;
    wire [`IRQ_WIDTH-1:0] irq_evt = {cfg_done, restart_done, |err_hit};
    wire rd_irq = rd_take && haddr == `OFF_IRQ_STATUS;
    always @(posedge core_clk) begin
        if (!rst_n) begin
            restart_reg <= 1'b0;
            err_reg <= 8'h00;
            mode_reg <= 2'h0;
            irq_stat_reg <= {`IRQ_WIDTH{1'b0}};
            irq_mask_reg <= {`IRQ_WIDTH{1'b0}};
            sw_settings_reg <= 1'b0;
        end else if (clk_en) begin
            if (restart_done) begin
                restart_reg <= 1'b0;
            end else if (wr_restart) begin
                restart_reg <= 1'b1;
            end
            // Restart clears errors; new errors in the same cycle still land
            if (restart_busy) begin
                err_reg <= err_hit;
            end else begin
                err_reg <= err_reg | err_hit;
            end
            if (wr && addr_reg == `OFF_ERRORS) begin
                err_reg <= (err_reg & hwdata[7:0]) | err_hit;
            end
            if (wr && addr_reg == `OFF_MODE) begin
                mode_reg <= hwdata[1:0];
            end
            if (wr && addr_reg == `OFF_IRQ_MASK) begin
                irq_mask_reg <= hwdata[`IRQ_WIDTH-1:0];
            end
            sw_settings_reg <= wr && addr_reg == `OFF_SETTINGS && hwdata[0];
            // Set wins over the read-clear
            if (rd_irq) begin
                irq_stat_reg <= irq_evt;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_evt;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Sub-blocks
    busy_timer #(.CYCLES(`RESTART_CYC)) u_restart (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        // Request bit clears one cycle after done; block a second start then
        .start(restart_reg && !restart_done),
        .busy(restart_busy),
        .done(restart_done)
    );
    busy_timer #(.CYCLES(`SETTINGS_CYC)) u_settings (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .start(settings_update || sw_settings_reg),
        .busy(cfg_busy),
        .done(cfg_done)
    );
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_unit
            unit_activity #(.TIMEOUT_CYC(LINK_TIMEOUT_CYC)) u_act (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .clear(restart_busy),
                .seen(rx_unit_valid && rx_unit == g),
                .active(activity[g])
            );
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////
    // Outputs and read data
    always @(posedge core_clk) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            port_reinit <= 1'b0;
            retry_poll <= 1'b0;
            link_enable <= 1'b0;
            settings_busy <= 1'b0;
            irq <= 1'b0;
        end else if (clk_en) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            port_reinit <= restart_busy;
            // Polling end retries on its own; errors do not stop the link
            retry_poll <= peer && !polled && |err_reg;
            link_enable <= !restart_busy && !cfg_busy;
            settings_busy <= cfg_busy;
            irq <= |(irq_stat_reg & irq_mask_reg);
            if (rd_take) begin
                case (haddr)
                    `OFF_ACTIVITY: hrdata <= {24'h000000, activity};
                    `OFF_RESTART: hrdata <= {31'h00000000, restart_reg};
                    `OFF_ERRORS: hrdata <= {24'h000000, err_reg};
                    `OFF_SETTINGS: hrdata <= {31'h00000000, cfg_busy};
                    `OFF_MODE: hrdata <= {30'h00000000, mode_reg};
                    `OFF_IRQ_STATUS: hrdata <= {29'h00000000, irq_stat_reg};
                    `OFF_IRQ_MASK: hrdata <= {29'h00000000, irq_mask_reg};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // serial_port_status_flags
`default_nettype wire

// file: common/serial_flags_defs.vh
`ifndef SERIAL_FLAGS_DEFS_VH
`define SERIAL_FLAGS_DEFS_VH
// Register byte offsets
`define OFF_ACTIVITY 12'h000
`define OFF_RESTART 12'h004
`define OFF_ERRORS 12'h008
`define OFF_SETTINGS 12'h00c
`define OFF_MODE 12'h010
`define OFF_IRQ_STATUS 12'h014
`define OFF_IRQ_MASK 12'h018
// Error field bit positions
`define ERR_PARITY 2
`define ERR_FRAMING 3
`define ERR_OVERRUN 4
`define ERR_TIMEOUT 5
`define ERR_USED_MASK 8'h3c
// Mode register layout
`define MODE_PEER_BIT 0
`define MODE_POLLED_BIT 1
// Interrupt status bits
`define IRQ_ERROR_BIT 0
`define IRQ_RESTART_DONE_BIT 1
`define IRQ_SETTINGS_DONE_BIT 2
`define IRQ_WIDTH 3
// Timing
`define CLK_HZ 20000000
`define LINK_TIMEOUT_US 1000
`define LINK_TIMEOUT_CYC ((`LINK_TIMEOUT_US * (`CLK_HZ / 1000000)))
`define RESTART_CYC 16
`define SETTINGS_CYC 16
`endif

// file: hw/unit_activity.v
`timescale 1ns/100ps
`default_nettype none
`include "serial_flags_defs.vh"
// One remote unit: active while answers keep arriving within the timeout
module unit_activity #(
    parameter TIMEOUT_CYC = 20000
) (
    input wire core_clk,
    input wire rst_n,
    input wire clk_en,
    input wire clear,
    input wire seen,
    output reg active
);
    reg [31:0] idle_reg;
    always @(posedge core_clk) begin
        if (!rst_n) begin
            active <= 1'b0;
            idle_reg <= 32'h0000_0000;
        end else if (clk_en) begin
            if (clear) begin
                active <= 1'b0;
                idle_reg <= 32'h0000_0000;
            end else if (seen) begin
                active <= 1'b1;
                idle_reg <= 32'h0000_0000;
            end else if (active) begin
                if (idle_reg >= TIMEOUT_CYC - 1) begin
                    active <= 1'b0;
                end else begin
                    idle_reg <= idle_reg + 32'h0000_0001;
                end
            end
        end
    end
endmodule // unit_activity
`default_nettype wire

// file: hw/busy_timer.v
`timescale 1ns/100ps
`default_nettype none
`include "serial_flags_defs.vh"
// Busy for a fixed number of cycles after start, one-cycle done pulse at end
module busy_timer #(
    parameter CYCLES = 16
) (
    input wire core_clk,
    input wire rst_n,
    input wire clk_en,
    input wire start,
    output reg busy,
    output reg done
);
    reg [7:0] cnt_reg;
    always @(posedge core_clk) begin
        if (!rst_n) begin
            busy <= 1'b0;
            done <= 1'b0;
            cnt_reg <= 8'h00;
        end else if (clk_en) begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                cnt_reg <= 8'h00;
            end else if (busy) begin
                if (cnt_reg == CYCLES - 1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 8'h01;
                end
            end
        end
    end
endmodule // busy_timer
`default_nettype wire

// file: verif/link_peer_model.sv
`timescale 1ns/100ps
`default_nettype none
module link_peer_model (
    input wire logic core_clk,
    input wire logic link_enable,
    output logic [2:0] rx_unit,
    output logic rx_unit_valid,
    output logic parity_err,
    output logic framing_err,
    output logic overrun_err,
    output logic timeout_err
);
    initial begin
        rx_unit = 3'h0;
        rx_unit_valid = 1'b0;
        {timeout_err, overrun_err, framing_err, parity_err} = 4'h0;
    end
    // A unit answers after gap cycles; a port in restart gets nothing
    task automatic answer(input logic [2:0] u, input int gap);
        repeat (gap) @(posedge core_clk);
        if (link_enable) begin
            rx_unit <= u;
            rx_unit_valid <= 1'b1;
            @(posedge core_clk);
            rx_unit_valid <= 1'b0;
            rx_unit <= ~u;
        end
    endtask
    // Faults come only when the bench orders them
    task automatic fault(input logic [3:0] e);
        {timeout_err, overrun_err, framing_err, parity_err} <= e;
        @(posedge core_clk);
        {timeout_err, overrun_err, framing_err, parity_err} <= 4'h0;
    endtask
endmodule // link_peer_model
`default_nettype wire

// file: verif/serial_port_status_flags_properties.sv
`timescale 1ns/100ps
`default_nettype none
module serial_port_status_flags_checker (
    input wire logic core_clk, rst_n, clk_en, settings_update, port_reinit,
    input wire logic settings_busy, link_enable, retry_poll, irq
);
    default clocking @(posedge core_clk); endclocking
    // A frozen clock enable stretches timed windows, so it disables every check except p_rst
    default disable iff (!rst_n || !clk_en);
    property p_rst; disable iff (1'b0)
        !rst_n |=> !port_reinit && !settings_busy && !irq && !retry_poll; endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
    property p_upd; settings_update && !settings_busy && !port_reinit |-> ##[1:2] settings_busy;
    endproperty
    a_upd: assert property (p_upd) else $error("update did not raise busy");
    property p_busy; $rose(settings_busy) |-> settings_busy[*8]; endproperty
    a_busy: assert property (p_busy) else $error("busy dropped early");
    property p_busy_end; $rose(settings_busy) |-> ##[8:24] !settings_busy; endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy never ends");
    property p_init; $rose(port_reinit) |-> port_reinit[*8]; endproperty
    a_init: assert property (p_init) else $error("restart cut short");
    property p_init_end; $rose(port_reinit) |-> ##[8:24] !port_reinit; endproperty
    a_init_end: assert property (p_init_end) else $error("restart never ends");
    property p_quiet; (port_reinit && $past(port_reinit)) ||
        (settings_busy && $past(settings_busy)) |-> !link_enable; endproperty
    a_quiet: assert property (p_quiet) else $error("link on during change");
    property p_retry; $fell(port_reinit) |-> ##[0:4] !retry_poll; endproperty
    a_retry: assert property (p_retry) else $error("errors survive restart");
    cover property ($rose(port_reinit));
    cover property ($rose(settings_busy));
    cover property ($rose(irq));
    cover property (retry_poll);
endmodule // serial_port_status_flags_checker
bind serial_port_status_flags serial_port_status_flags_checker u_chk (.core_clk, .rst_n, .clk_en,
    .settings_update, .port_reinit, .settings_busy, .link_enable, .retry_poll, .irq);
`default_nettype wire

// file: verif/serial_port_status_flags_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module serial_port_status_flags_test;
    logic core_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, settings_update = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [11:0] haddr = 12'h000;
    logic [31:0] hwdata = 32'h0, r;
    logic clk_en = 1'b1;
    wire [2:0] hsize = 3'h2;
    wire hreadyout, hresp, port_reinit, retry_poll, link_enable, settings_busy, irq;
    wire hready = hreadyout;
    wire rx_unit_valid, parity_err, framing_err, overrun_err, timeout_err;
    wire [2:0] rx_unit;
    wire [31:0] hrdata;
    int num_errors = 0, n_compared = 0, i;
    always #25 core_clk = ~core_clk;
    serial_port_status_flags #(.LINK_TIMEOUT_CYC(20)) u_serial_port_status_flags (.*);
    link_peer_model u_link_peer_model (.*);
    ////////////////////
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0);
        `CHK(n, e, r)
    endtask
    task restart;
        bus(1'b1, 12'h004, 32'h1);
        bus(1'b0, 12'h004, 32'h0);
        `CHK("restart set", 1'b1, r[0])
        for (i = 0; i < 30 && r[0] !== 1'b0; i++) bus(1'b0, 12'h004, 32'h0);
        `CHK("restart self clear", 1'b0, r[0])
        rd(12'h008, 32'h0, "errors cleared");
    endtask
    ////////////////////
    task t_reset;
        rd(12'h000, 32'h0, "activity");
        rd(12'h004, 32'h0, "restart");
        rd(12'h008, 32'h0, "errors");
        rd(12'h00c, 32'h0, "settings");
        bus(1'b1, 12'h0fc, 32'hffffffff);
        rd(12'h0fc, 32'h0, "unmapped");
        `CHK("okay", 1'b0, hresp)
    endtask
    task t_activity;
        for (i = 0; i < 8; i++) u_link_peer_model.answer(i[2:0], 1);
        rd(12'h000, 32'hff, "all units");
        repeat (30) @(posedge core_clk);
        rd(12'h000, 32'h0, "silent units");
        bus(1'b1, 12'h010, 32'h1);
        u_link_peer_model.answer(3'h5, 3);
        rd(12'h000, 32'h20, "peer unit");
    endtask
    task t_settings;
        @(posedge core_clk);
        settings_update <= 1'b1;
        @(posedge core_clk);
        settings_update <= 1'b0;
        rd(12'h00c, 32'h1, "busy");
        `CHK("link held", 1'b0, link_enable)
        clk_en <= 1'b0;
        repeat (30) @(posedge core_clk);
        `CHK("frozen busy", 1'b1, settings_busy)
        clk_en <= 1'b1;
        for (i = 0; i < 40 && settings_busy !== 1'b0; i++) @(posedge core_clk);
        rd(12'h00c, 32'h0, "settled");
        bus(1'b1, 12'h00c, 32'h1);
        rd(12'h00c, 32'h1, "sw busy");
        for (i = 0; i < 40 && settings_busy !== 1'b0; i++) @(posedge core_clk);
        rd(12'h00c, 32'h0, "sw settled");
    endtask
    task t_errors;
        bus(1'b1, 12'h010, 32'h0);
        u_link_peer_model.fault(4'hf);
        rd(12'h008, 32'h20, "terminal errors");
        restart;
        bus(1'b1, 12'h010, 32'h3);
        u_link_peer_model.fault(4'hf);
        rd(12'h008, 32'h38, "polled errors");
        restart;
        bus(1'b1, 12'h010, 32'h1);
        u_link_peer_model.fault(4'hf);
        rd(12'h008, 32'h20, "polling errors");
        `CHK("retry", 1'b1, retry_poll)
        u_link_peer_model.answer(3'h2, 0);
        rd(12'h000, 32'h4, "resumed");
        rd(12'h008, 32'h20, "errors kept");
        restart;
        `CHK("retry off", 1'b0, retry_poll)
    endtask
    task t_irq;
        bus(1'b1, 12'h010, 32'h0);
        bus(1'b0, 12'h014, 32'h0);
        bus(1'b1, 12'h018, 32'h0);
        u_link_peer_model.fault(4'h8);
        @(posedge core_clk);
        `CHK("irq masked", 1'b0, irq)
        bus(1'b1, 12'h018, 32'h1);
        repeat (2) @(posedge core_clk);
        `CHK("irq raised", 1'b1, irq)
        rd(12'h014, 32'h1, "irq status");
        @(posedge core_clk);
        `CHK("irq cleared", 1'b0, irq)
    endtask
    ////////////////////
    task give_verdict;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset;
        t_activity;
        t_settings;
        t_errors;
        t_irq;
        give_verdict;
    end
    // Whole run needs about 300 cycles
    initial begin
        repeat (8000) @(posedge core_clk);
        num_errors++;
        give_verdict;
    end
endmodule // serial_port_status_flags_test
`default_nettype wire
